// ### arf_top.sv
// Digital back end of a 12-bit SAR converter: power control, burst, justification, accumulate.
// Assumes the analog core answers each start with one done pulse carrying its code.
`default_nettype none
module arf_top
	import arf_pkg::*;
(
	input  wire logic                       clk_sys,
	input  wire logic                       rst,
	input  wire logic                       converter_enable_bit,
	input  wire logic                       burst_mode_bit,
	input  wire logic                       left_justify_bit,
	input  wire logic [arf_pkg::RPT_W-1:0]  repeat_count_field,
	input  wire logic                       start_request,
	input  wire logic                       conv_done,
	input  wire logic [arf_pkg::CODE_W-1:0] conv_code,
	output var  logic                       converter_power_on,
	output var  logic                       conv_start,
	output var  logic                       busy,
	output var  logic                       result_ready,
	output var  logic [7:0]                 result_high_byte,
	output var  logic [7:0]                 result_low_byte
);
	import arf_pkg::*;

	arf_state_t  state_ff;
	arf_state_t  nxt_state;
	logic [4:0]  cnt_ff;
	logic [4:0]  nxt_cnt;
	logic [15:0] acc_ff;
	logic [15:0] nxt_acc;
	logic        burst_ff;
	logic [1:0]  rpt_ff;
	logic        lj_ff;
	logic        load;
	logic [15:0] load_val;
	logic [15:0] res_q;
	logic        last;

	// Samples per set from the repeat field
	function automatic logic [4:0] set_size(input logic [1:0] rpt);
		unique case (rpt)
			RPT_1:   set_size = SET_1;
			RPT_4:   set_size = SET_4;
			RPT_8:   set_size = SET_8;
			RPT_16:  set_size = SET_16;
		endcase
	endfunction : set_size

	// Start-of-set condition: software request while the enable bit or the burst bit is set
	logic go;
	assign go = start_request && (converter_enable_bit || burst_mode_bit);

	// A set is taken only from idle; a start while busy is dropped
	logic take;
	assign take = (state_ff == ST_IDLE) && go;

	// Code widened to the sum width with zero top bits, so the sum stays unsigned
	logic [15:0] code_ext;
	assign code_ext = {{LJ_SHIFT{1'b0}}, conv_code};

	// Last sample of the set: the count after this one reaches the set size
	assign last = (cnt_ff + CNT_ONE) >= set_size(rpt_ff);

	// Sequencer next state
	always_comb
	begin
		nxt_state = state_ff;
		nxt_cnt   = cnt_ff;
		nxt_acc   = acc_ff;
		unique case (state_ff)
			// Idle: a new set clears count and sum before its first sample
			ST_IDLE:
			begin
				if (go)
				begin
					nxt_state = ST_CONV;
					nxt_cnt   = CNT_RST;
					nxt_acc   = RES_RST;
				end
			end
			// Convert: one cycle in which the start strobe stands
			ST_CONV:
				nxt_state = ST_WAIT;
			// Wait: each done adds a sample; the last one ends the set
			ST_WAIT:
			begin
				if (conv_done)
				begin
					nxt_acc = acc_ff + code_ext;
					nxt_cnt = cnt_ff + CNT_ONE;
					nxt_state = last ? ST_IDLE : ST_CONV;
				end
			end
			default:
				nxt_state = ST_IDLE;
		endcase
	end

	// Current step of the sequencer
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// Samples taken so far in this set
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			cnt_ff <= CNT_RST;
		else
			cnt_ff <= nxt_cnt;
	end

	// Running sum; 16 bits hold sixteen full-scale codes with no carry out
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			acc_ff <= RES_RST;
		else
			acc_ff <= nxt_acc;
	end

	// Burst flag latched at set start: it holds power up until the set ends
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			burst_ff <= 1'b0;
		else if (take)
			burst_ff <= burst_mode_bit;
	end

	// Repeat code latched at set start so a mid-set write cannot split a sum
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			rpt_ff <= RPT_1;
		else if (take)
			rpt_ff <= repeat_count_field;
	end

	// Justify bit latched with the set so the format matches the data it frames
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			lj_ff <= 1'b0;
		else if (take)
			lj_ff <= left_justify_bit;
	end

	// Result written only when the final sample of the set lands
	assign load = (state_ff == ST_WAIT) && conv_done && last;
	// Left justify is honoured for single codes only; sums stay right aligned
	always_comb
	begin
		if (lj_ff && rpt_ff == RPT_1)
			load_val = nxt_acc << LJ_SHIFT;
		else
			load_val = nxt_acc;
	end

	// Holding register: read data come from its flop, never from the adder
	arf_result_reg #(
		.W (RES_W)
	) u_res (
		.clk_sys (clk_sys),
		.rst     (rst),
		.load    (load),
		.din     (load_val),
		.dout    (res_q)
	);

	// A burst set keeps power up for its own length; its start cycle uses the live bit
	logic burst_run;
	assign burst_run = ((state_ff != ST_IDLE) && (nxt_state != ST_IDLE) && burst_ff) ||
		(take && burst_mode_bit);

	// Power: enable bit holds it on; a burst set holds it on only while running
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			converter_power_on <= 1'b0;
		else
			converter_power_on <= converter_enable_bit || burst_run;
	end

	// One start strobe per sample, raised as the sequencer enters the convert step
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			conv_start <= 1'b0;
		else
			conv_start <= (nxt_state == ST_CONV);
	end

	// Ready pulse lands with the new bytes and stands one cycle
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			result_ready <= 1'b0;
		else
			result_ready <= load;
	end

	// Busy is a handshake level straight from state; the bytes split the result flop
	assign busy             = (state_ff != ST_IDLE);
	assign result_high_byte = res_q[15:8];
	assign result_low_byte  = res_q[7:0];
endmodule : arf_top
`default_nettype wire

// ### arf_pkg.sv
// Package for the converter result formatter and accumulator.
// Assumes a 12-bit successive-approximation core outside this block.
`default_nettype none
package arf_pkg;
	localparam int CODE_W = 12;
	localparam int RES_W  = 16;
	localparam int RPT_W  = 2;
	// Repeat count field encodings
	localparam logic [1:0] RPT_1  = 2'h0;
	localparam logic [1:0] RPT_4  = 2'h1;
	localparam logic [1:0] RPT_8  = 2'h2;
	localparam logic [1:0] RPT_16 = 2'h3;
	// Left shift that places a 12-bit code in the high bits
	localparam int LJ_SHIFT = RES_W - CODE_W;
	localparam logic [15:0] RES_RST = 16'h0000;
	localparam logic [4:0]  CNT_RST = 5'h00;
	localparam logic [4:0]  CNT_ONE = 5'h01;
	// Samples per set for each repeat code
	localparam logic [4:0]  SET_1   = 5'h01;
	localparam logic [4:0]  SET_4   = 5'h04;
	localparam logic [4:0]  SET_8   = 5'h08;
	localparam logic [4:0]  SET_16  = 5'h10;
	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_CONV = 2'b01,
		ST_WAIT = 2'b10
	} arf_state_t;
endpackage : arf_pkg
`default_nettype wire

// ### arf_result_reg.sv
// Result byte pair holding register with registered read data.
// Assumes the load strobe and data come from logic on clk_sys.
`default_nettype none
module arf_result_reg #(
	parameter int W = 16
) (
	input  wire logic         clk_sys,
	input  wire logic         rst,
	input  wire logic         load,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	import arf_pkg::*;
	// Holds the last completed result until the next load
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			dout <= '0;
		else if (load)
			dout <= din;
	end
endmodule : arf_result_reg
`default_nettype wire

// ### arf_chk.sv
// Port assertions for arf_top.
// Assumes a bind from the bench, one clock domain.
`default_nettype none
module arf_chk (
	input wire logic       clk_sys,
	input wire logic       rst,
	input wire logic       converter_enable_bit,
	input wire logic       burst_mode_bit,
	input wire logic       start_request,
	input wire logic       conv_done,
	input wire logic       converter_power_on,
	input wire logic       conv_start,
	input wire logic       busy,
	input wire logic       result_ready,
	input wire logic [7:0] result_high_byte,
	input wire logic [7:0] result_low_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	// A start is taken only when idle and the enable bit or the burst bit is set
	sequence go_s;
		start_request && !busy && (converter_enable_bit || burst_mode_bit);
	endsequence
	start_go_a: assert property (go_s |=> conv_start && busy) else $error("no start");
	start_one_a: assert property (conv_start |=> !conv_start) else $error("long start");
	start_idle_a: assert property (!busy && !start_request |=> !conv_start)
		else $error("stray start");
	power_busy_a: assert property (busy |-> converter_power_on) else $error("unpowered");
	power_off_a: assert property ((!converter_enable_bit && !busy)[*2] |-> !converter_power_on)
		else $error("not shut down");
	done_next_a: assert property (conv_done && busy |=> result_ready || conv_start)
		else $error("done lost");
	ready_end_a: assert property (result_ready |-> !busy && !conv_start) else $error("ready");
	// Bytes move only with the ready pulse, so partial sums never show
	bytes_hold_a: assert property (!result_ready |-> $stable({result_high_byte, result_low_byte}))
		else $error("bytes moved");
endmodule : arf_chk
`default_nettype wire

// ### arf_core_model.sv
// Behavioural SAR core: one done pulse per start.
// Assumes the bench supplies the code to return; spread asks for random codes instead.
`default_nettype none
module arf_core_model (
	input wire logic        clk_sys,
	input wire logic        rst,
	input wire logic        conv_start,
	input wire logic [11:0] sample_code,
	input wire logic        spread,
	output var logic        conv_done,
	output var logic [11:0] conv_code
);
	timeunit 1ns;
	timeprecision 1ps;
	// Latency 1 to 4 cycles; code toggles each cycle outside a conversion and holds during the latency
	initial
	begin
		conv_done = 1'b0;
		conv_code = 12'hA5A;
		forever
		begin
			@(posedge clk_sys);
			#1 conv_done = 1'b0;
			conv_code = ~conv_code;
			if (conv_start === 1'b1 && !rst)
			begin
				repeat (1 + $urandom % 4) @(posedge clk_sys);
				#1 conv_done = 1'b1;
				conv_code = spread ? 12'($urandom) : sample_code;
			end
		end
	end
endmodule : arf_core_model
`default_nettype wire

// ### arf_top_bench.sv
// Self-checking bench for arf_top.
// Assumes arf_pkg, arf_core_model and arf_chk compiled.
`default_nettype none
module arf_top_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import arf_pkg::*;
	logic clk_sys, rst, converter_enable_bit, burst_mode_bit, left_justify_bit;
	logic start_request, conv_done, converter_power_on, conv_start, busy, result_ready;
	logic [1:0] repeat_count_field;
	logic [11:0] code, conv_code;
	logic [7:0] result_high_byte, result_low_byte;
	logic [31:0] v;
	logic spread;
	logic [15:0] sum_exp;
	logic [11:0] corner [4] = '{12'hFFF, 12'h800, 12'h7FF, 12'h000};
	int n_mismatch, total_checks, k;
	arf_top dut_u (.clk_sys, .rst, .converter_enable_bit, .burst_mode_bit, .left_justify_bit,
		.repeat_count_field, .start_request, .conv_done, .conv_code, .converter_power_on,
		.conv_start, .busy, .result_ready, .result_high_byte, .result_low_byte);
	arf_core_model core_u (.clk_sys, .rst, .conv_start, .sample_code(code), .spread,
		.conv_done, .conv_code);
	// Sum of the codes the core hands over, cleared while a start is asked for
	always @(posedge clk_sys)
		if (start_request)
			sum_exp <= '0;
		else if (conv_done === 1'b1)
			sum_exp <= sum_exp + {4'h0, conv_code};
	// Equal samples: sum is the code shifted by log2 of the count
	function automatic logic [15:0] expv(input logic j, input logic [1:0] r, input logic [11:0] c);
		return (r == RPT_1) ? (j ? {c, 4'h0} : {4'h0, c}) : ({4'h0, c} << ({1'b0, r} + 3'h1));
	endfunction : expv
	task check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task conclude;
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : conclude
	// One set; the wait is bounded so a lost result ends the run
	task run(input logic e, input logic b, input logic j, input logic [1:0] r,
		input logic [11:0] c, input logic s);
		int w;
		{converter_enable_bit, burst_mode_bit, left_justify_bit} = {e, b, j};
		{repeat_count_field, code, spread, start_request} = {r, c, s, 1'b1};
		// Start held one more edge: refused while busy; the settings change must not leak in
		@(posedge clk_sys) #1 {repeat_count_field, left_justify_bit} = {~r, 1'b0};
		@(posedge clk_sys) #1 start_request = 1'b0;
		for (w = 0; w < 200 && result_ready !== 1'b1; w++)
			@(posedge clk_sys) #1;
		if (w == 200)
		begin
			n_mismatch++;
			conclude;
		end
		check({result_high_byte, result_low_byte}, j ? sum_exp << LJ_SHIFT : sum_exp);
		if (!s)
			check({result_high_byte, result_low_byte}, expv(j, r, c));
		check({15'h0000, converter_power_on}, {15'h0000, e});
	endtask : run
	initial
	begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	initial
	begin
		{n_mismatch, total_checks} = '0;
		{rst, converter_enable_bit, burst_mode_bit, left_justify_bit} = 4'hF;
		{repeat_count_field, code, spread, start_request} = '0;
		k = $urandom(39);
		repeat (6) @(posedge clk_sys);
		#1 rst = 1'b0;
		check({12'h000, converter_power_on, conv_start, busy, result_ready}, 16'h0000);
		// Corner codes at every count; justify only for single samples
		for (k = 0; k < 32; k++)
			run(k[0], ~k[0], (k[4:3] == 2'h0) & k[0], k[4:3], corner[k[2:1]], 1'b0);
		// Mid-run reset clears every output; a start with neither enable nor burst is refused
		@(posedge clk_sys) #1 rst = 1'b1;
		{converter_enable_bit, burst_mode_bit, start_request} = 3'b001;
		@(posedge clk_sys) #1 rst = 1'b0;
		check({result_high_byte, result_low_byte}, RES_RST);
		check({12'h000, converter_power_on, conv_start, busy, result_ready}, 16'h0000);
		@(posedge clk_sys) #1 start_request = 1'b0;
		check({14'h0000, busy, converter_power_on}, 16'h0000);
		for (k = 0; k < 40; k++)
		begin
			v = $urandom;
			run(v[0], ~v[0] | v[1], (v[3:2] == 2'h0) & v[4], v[3:2], v[16:5], v[17]);
		end
		conclude;
	end
endmodule : arf_top_bench
bind arf_top arf_chk chk_u (.clk_sys, .rst, .converter_enable_bit, .burst_mode_bit,
	.start_request, .conv_done, .converter_power_on, .conv_start, .busy, .result_ready,
	.result_high_byte, .result_low_byte);
`default_nettype wire
